// ### rtl/dvf_act_mon.sv
`timescale 1ns/100ps

module dvf_act_mon #(
    parameter int IDLE_CYC = 10000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Synchronised data-enable
    input wire logic de,
    // Link activity
    output logic active
);

    localparam int CW = $clog2(IDLE_CYC + 1);

    logic de_prev_q;
    logic [CW-1:0] idle_q;

    if (IDLE_CYC < 2) begin : g_bad_idle
        $error("dvf_act_mon: IDLE_CYC must be at least 2");
    end

    // ======================================================================
    // Previous data-enable for toggle detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            de_prev_q <= 1'b0;
        end else begin
            de_prev_q <= de;
        end
    end

    // Idle counter: cleared by each toggle, drops activity when it expires
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_q <= '0;
            active <= 1'b0;
        end else if (de != de_prev_q) begin
            idle_q <= '0;
            active <= 1'b1;
        end else if (idle_q == CW'(IDLE_CYC - 1)) begin
            active <= 1'b0;
        end else begin
            idle_q <= idle_q + 1'b1;
        end
    end

endmodule

// ### rtl/dvf_cfg.svh
`ifndef DVF_CFG_SVH
`define DVF_CFG_SVH

// ==========================================================================
// Register map (byte addresses on the AXI4-Lite bus)
`define DVF_ADDR_W 4
`define DVF_OFS_CTRL 4'h0
`define DVF_OFS_STATUS 4'h4
`define DVF_OFS_IRQ_STAT 4'h8
`define DVF_OFS_IRQ_MASK 4'hc

// ==========================================================================
// Control register fields and reset values
`define DVF_CTRL_PIX_SEL 0
`define DVF_CTRL_STAGGER_SELECT_N_N 1
`define DVF_CTRL_EDGE_SEL 2
`define DVF_CTRL_PDO_N 3
`define DVF_CTRL_W 4
`define DVF_CTRL_RST 4'he

// ==========================================================================
// Status and interrupt fields
`define DVF_ST_LINK_ACT 0
`define DVF_ST_DE 1
`define DVF_IRQ_UP 0
`define DVF_IRQ_DOWN 1
`define DVF_IRQ_W 2
`define DVF_IRQ_MASK_RST 2'h0

// ==========================================================================
// AXI responses
`define DVF_RESP_OKAY 2'h0
`define DVF_RESP_SLVERR 2'h2

// ==========================================================================
// Timing: link is judged idle after this long without a data-enable toggle
`define DVF_CLK_PERIOD_NS 10
`define DVF_IDLE_TIME_NS 100000
`define DVF_IDLE_CYC (`DVF_IDLE_TIME_NS / `DVF_CLK_PERIOD_NS)

`endif

// ### rtl/dvf_fmt.sv
`timescale 1ns/100ps
`include "dvf_cfg.svh"

module dvf_fmt #(
    parameter int IDLE_CYC = `DVF_IDLE_CYC
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Decoded link, asynchronous to CORE_CLK
    input wire logic LINK_CLK,
    input wire logic DATA_ENABLE_IN,
    input wire logic [7:0] CH0_DATA,
    input wire logic [7:0] CH1_DATA,
    input wire logic [7:0] CH2_DATA,
    input wire logic [1:0] CH0_CTL,
    input wire logic CH1_CTL,
    input wire logic CH2_CTL,
    // Pixel output pins
    output dvf_pkg::dvf_pixel_t EVEN_PIXEL_BUS,
    output dvf_pkg::dvf_pixel_t ODD_PIXEL_BUS,
    output logic HSYNC,
    output logic VSYNC,
    output logic DATA_ENABLE,
    output logic CONTROL_BIT_ONE,
    output logic CONTROL_BIT_TWO,
    output logic PIXEL_OUT_CLOCK,
    output logic LINK_ACTIVE_FLAG,
    output logic PIX_OE_N,
    // Interrupt
    output logic IRQ,
    // AXI4-Lite write
    input wire logic [`DVF_ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read
    input wire logic [`DVF_ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    import dvf_pkg::*;

    localparam int SW = 30;

    logic [SW-1:0] sync_s;
    logic [SW-1:0] prev_q;
    logic lclk_s;
    logic de_s;
    logic lclk_p;
    logic de_c;
    dvf_pixel_t pix_c;
    logic [3:0] ctl_c;
    logic rise;
    logic fall;
    logic act;
    logic [`DVF_CTRL_W-1:0] ctrl_q;
    logic [`DVF_IRQ_W-1:0] irq_stat_q;
    logic [`DVF_IRQ_W-1:0] irq_mask_q;
    logic act_prev_q;
    logic [`DVF_IRQ_W-1:0] irq_set;
    logic pix2;
    logic stagger_select_n;
    logic edge_sel;
    dvf_phase_e phase_q;
    logic de_last_q;
    logic eff_even;
    dvf_pixel_t even_hold_q;
    dvf_pixel_t st_even_q;
    dvf_pixel_t st_odd_q;
    logic st_de_q;
    logic [3:0] ctl_q;
    logic oclk_rise;
    logic oclk_fall;
    logic upd_even;
    logic upd_odd;
    logic wr_go;
    logic rd_clr;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    logic [`DVF_ADDR_W-1:0] aw_q;
    logic [31:0] wd_q;
    logic ws_q;
    dvf_pixel_t odd_show_q;

    // ======================================================================
    // Link input crossing
    // Two flip-flops on every link input before any logic looks at it
    dvf_sync #(
        .WIDTH(SW)
    ) u_sync (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .d({LINK_CLK, DATA_ENABLE_IN, CH2_DATA, CH1_DATA, CH0_DATA,
            CH2_CTL, CH1_CTL, CH0_CTL}),
        .q(sync_s)
    );

    // One more stage so a capture sees data from just before the edge
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            prev_q <= '0;
        end else begin
            prev_q <= sync_s;
        end
    end

    assign lclk_s = sync_s[SW-1];
    assign de_s = sync_s[SW-2];
    assign lclk_p = prev_q[SW-1];
    assign de_c = prev_q[SW-2];
    assign pix_c = de_c ? prev_q[27:4] : '0;
    assign ctl_c = prev_q[3:0];
    assign rise = lclk_s & ~lclk_p;
    assign fall = ~lclk_s & lclk_p;

    // ======================================================================
    // Link activity
    dvf_act_mon #(
        .IDLE_CYC(IDLE_CYC)
    ) u_act (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .de(de_s),
        .active(act)
    );

    // ======================================================================
    // Mode selection from the control register
    assign pix2 = ctrl_q[`DVF_CTRL_PIX_SEL];
    assign stagger_select_n = pix2 & ~ctrl_q[`DVF_CTRL_STAGGER_SELECT_N_N];
    assign edge_sel = ctrl_q[`DVF_CTRL_EDGE_SEL];

    // First active pixel of a line is always the even one
    assign eff_even = (phase_q == DVF_PH_EVEN) | (de_c & ~de_last_q);

    // Phase of the pair and line start tracking
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            phase_q <= DVF_PH_EVEN;
            de_last_q <= 1'b0;
        end else if (rise) begin
            de_last_q <= de_c;
            if (!pix2 || !eff_even) begin
                phase_q <= DVF_PH_EVEN;
            end else begin
                phase_q <= DVF_PH_ODD;
            end
        end
    end

    // ======================================================================
    // Pixel staging: one pixel, or a completed even/odd pair
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            even_hold_q <= '0;
            st_even_q <= '0;
            st_odd_q <= '0;
            st_de_q <= 1'b0;
        end else if (rise) begin
            if (!pix2) begin
                st_even_q <= pix_c;
                st_odd_q <= '0;
                st_de_q <= de_c;
            end else if (eff_even) begin
                even_hold_q <= pix_c;
            end else begin
                st_even_q <= even_hold_q;
                st_odd_q <= pix_c;
                st_de_q <= de_c;
            end
        end
    end

    // Control bits sampled during blanking only, held through active video
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ctl_q <= '0;
        end else if (rise && !de_c) begin
            ctl_q <= ctl_c;
        end
    end

    // ======================================================================
    // Output clock edges: follow the link clock, or half its rate in pairs
    always_comb begin
        if (pix2) begin
            oclk_rise = rise & eff_even;
            oclk_fall = rise & ~eff_even;
        end else begin
            oclk_rise = rise;
            oclk_fall = fall;
        end
    end

    // Data changes on the edge opposite the one the receiver latches on
    assign upd_even = edge_sel ? oclk_fall : oclk_rise;
    assign upd_odd = stagger_select_n ? (edge_sel ? oclk_rise : oclk_fall)
                          : upd_even;

    // Output clock
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            PIXEL_OUT_CLOCK <= 1'b0;
        end else if (oclk_rise) begin
            PIXEL_OUT_CLOCK <= 1'b1;
        end else if (oclk_fall) begin
            PIXEL_OUT_CLOCK <= 1'b0;
        end
    end

    // Even bus and control outputs
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            EVEN_PIXEL_BUS <= '0;
            DATA_ENABLE <= 1'b0;
            {CONTROL_BIT_TWO, CONTROL_BIT_ONE, VSYNC, HSYNC} <= 4'h0;
        end else if (upd_even) begin
            EVEN_PIXEL_BUS <= st_even_q;
            DATA_ENABLE <= st_de_q;
            {CONTROL_BIT_TWO, CONTROL_BIT_ONE, VSYNC, HSYNC} <= ctl_q;
        end
    end

    // Odd half of the pair now on the even bus, so a staggered odd
    // update trails its own even pixel instead of leading the next pair
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            odd_show_q <= '0;
        end else if (upd_even) begin
            odd_show_q <= st_odd_q;
        end
    end

    // Odd bus, low whenever one pixel per clock is chosen
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ODD_PIXEL_BUS <= '0;
        end else if (!pix2) begin
            ODD_PIXEL_BUS <= '0;
        end else if (upd_odd) begin
            ODD_PIXEL_BUS <= stagger_select_n ? odd_show_q : st_odd_q;
        end
    end

    // Link flag and output enable of the releasable pins
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            LINK_ACTIVE_FLAG <= 1'b0;
            PIX_OE_N <= 1'b0;
        end else begin
            LINK_ACTIVE_FLAG <= act;
            PIX_OE_N <= ~ctrl_q[`DVF_CTRL_PDO_N];
        end
    end

    // ======================================================================
    // Interrupts: link up and link down, sticky, cleared by a read of the interrupt status register
    assign irq_set = {act_prev_q & ~act, act & ~act_prev_q};
    assign rd_clr = ARVALID & ARREADY & (ARADDR == `DVF_OFS_IRQ_STAT);

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            act_prev_q <= 1'b0;
            irq_stat_q <= '0;
            IRQ <= 1'b0;
        end else begin
            act_prev_q <= act;
            irq_stat_q <= (rd_clr ? '0 : irq_stat_q) | irq_set;
            IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ======================================================================
    // AXI4-Lite write: address and data taken in either order
    assign wr_go = ~AWREADY & ~WREADY & ~BVALID;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= `DVF_RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY) begin
                WREADY <= 1'b0;
            end
            if (wr_go) begin
                BVALID <= 1'b1;
                if (awaddr_ok(aw_q)) begin
                    BRESP <= `DVF_RESP_OKAY;
                end else begin
                    BRESP <= `DVF_RESP_SLVERR;
                end
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    // Latched write address and data
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            aw_q <= '0;
            wd_q <= '0;
            ws_q <= 1'b0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                wd_q <= WDATA;
                ws_q <= WSTRB[0];
            end
        end
    end

    function automatic logic awaddr_ok(input logic [`DVF_ADDR_W-1:0] a);
        awaddr_ok = (a == `DVF_OFS_CTRL) || (a == `DVF_OFS_STATUS) ||
                    (a == `DVF_OFS_IRQ_STAT) || (a == `DVF_OFS_IRQ_MASK);
    endfunction

    // Writable registers, low byte lane only
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ctrl_q <= `DVF_CTRL_RST;
            irq_mask_q <= `DVF_IRQ_MASK_RST;
        end else if (wr_go && ws_q) begin
            if (aw_q == `DVF_OFS_CTRL) begin
                ctrl_q <= wd_q[`DVF_CTRL_W-1:0];
            end else if (aw_q == `DVF_OFS_IRQ_MASK) begin
                irq_mask_q <= wd_q[`DVF_IRQ_W-1:0];
            end
        end
    end

    // ======================================================================
    // AXI4-Lite read
    always_comb begin
        rd_data = 32'h0;
        rd_resp = `DVF_RESP_OKAY;
        if (ARADDR == `DVF_OFS_CTRL) begin
            rd_data[`DVF_CTRL_W-1:0] = ctrl_q;
        end else if (ARADDR == `DVF_OFS_STATUS) begin
            rd_data[`DVF_ST_LINK_ACT] = act;
            rd_data[`DVF_ST_DE] = de_s;
        end else if (ARADDR == `DVF_OFS_IRQ_STAT) begin
            rd_data[`DVF_IRQ_W-1:0] = irq_stat_q;
        end else if (ARADDR == `DVF_OFS_IRQ_MASK) begin
            rd_data[`DVF_IRQ_W-1:0] = irq_mask_q;
        end else begin
            rd_resp = `DVF_RESP_SLVERR;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= `DVF_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= rd_data;
            RRESP <= rd_resp;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

endmodule

// ### rtl/dvf_pkg.sv
package dvf_pkg;

    // Pixel phase within a two-pixel pair
    typedef enum logic {
        DVF_PH_EVEN,
        DVF_PH_ODD
    } dvf_phase_e;

    // One 24-bit pixel: red 23:16, green 15:8, blue 7:0
    typedef logic [23:0] dvf_pixel_t;

endpackage

// ### rtl/dvf_sync.sv
`timescale 1ns/100ps

module dvf_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous input and its synchronised copy
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("dvf_sync: WIDTH must be at least 1");
    end

    // ======================================================================
    // Two-stage synchroniser, one per bit
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                meta_q[i] <= 1'b0;
                q[i] <= 1'b0;
            end else begin
                meta_q[i] <= d[i];
                q[i] <= meta_q[i];
            end
        end
    end

endmodule

// ### testbench/dvf_fmt_sva.sv
`timescale 1ns/100ps
// ============================================================
// Register bus and pixel timing checker
module dvf_fmt_sva #(
    parameter int IDLE_CYC = 10000
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Link and pixel pins
    input wire logic DATA_ENABLE_IN,
    input dvf_pkg::dvf_pixel_t EVEN_PIXEL_BUS,
    input wire logic DATA_ENABLE,
    input wire logic PIXEL_OUT_CLOCK,
    input wire logic LINK_ACTIVE_FLAG,
    // Register bus handshakes
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY
);
    import dvf_pkg::*;
    int idle_q;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    // Cycles since the link data-enable last moved, saturating
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN || $changed(DATA_ENABLE_IN))
            idle_q <= 0;
        else if (idle_q <= IDLE_CYC + 8)
            idle_q <= idle_q + 1;
    end

    a_write_answer: assert property (
        AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write response not two cycles after handshake");
    a_write_busy: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while a response is pending");
    a_read_answer: assert property (
        ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read data not one cycle after address");
    a_read_release: assert property (RVALID && RREADY |=> !RVALID)
        else $error("read data held after handshake");
    a_bus_on_clock: assert property (
        $changed(EVEN_PIXEL_BUS) |-> $changed(PIXEL_OUT_CLOCK))
        else $error("pixel bus moved off the output clock");
    a_de_on_clock: assert property (
        $changed(DATA_ENABLE) |-> $changed(PIXEL_OUT_CLOCK))
        else $error("data enable moved off the output clock");
    a_link_seen: assert property (
        $changed(DATA_ENABLE_IN) |-> ##[1:8] LINK_ACTIVE_FLAG)
        else $error("link flag not raised by a toggle");
    a_link_idle: assert property (
        idle_q > IDLE_CYC + 8 |-> !LINK_ACTIVE_FLAG)
        else $error("link flag high on an idle link");

    // Main scenarios
    c_link_up: cover property ($rose(LINK_ACTIVE_FLAG));
    c_link_down: cover property ($fell(LINK_ACTIVE_FLAG));
    c_write_done: cover property (BVALID && BREADY);
endmodule

bind dvf_fmt dvf_fmt_sva #(.IDLE_CYC(IDLE_CYC)) dvf_fmt_sva_i (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .DATA_ENABLE_IN(DATA_ENABLE_IN),
    .EVEN_PIXEL_BUS(EVEN_PIXEL_BUS), .DATA_ENABLE(DATA_ENABLE),
    .PIXEL_OUT_CLOCK(PIXEL_OUT_CLOCK), .LINK_ACTIVE_FLAG(LINK_ACTIVE_FLAG),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
    .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY)
);

// ### testbench/dvf_link_src.sv
`timescale 1ns/100ps
// ============================================================
// Decoded link source: clock runs only within a line
module dvf_link_src (
    // Decoded link toward the formatter
    output logic link_clk,
    output logic de,
    output logic [7:0] ch0,
    output logic [7:0] ch1,
    output logic [7:0] ch2,
    output logic [1:0] ctl0,
    output logic control_bit_one,
    output logic control_bit_two
);
    // Pixels of the current line as red, green, blue
    logic [23:0] sent_q[$];
    logic [23:0] pat;

    // Idle link, clock parked low
    initial begin
        {link_clk, de, ch2, ch1, ch0, ctl0, control_bit_one, control_bit_two} = '0;
    end

    // One 125 ns link period; inputs move while the clock is low
    task automatic tick(input logic d, input logic [23:0] v);
        de = d;
        {ch2, ch1, ch0} = v;
        #62.5 link_clk = 1;
        #62.5 link_clk = 0;
    endtask

    // Blanking, active pixels, blanking; data lines churn in blanking
    task automatic line(input int n);
        sent_q = {};
        {control_bit_two, control_bit_one, ctl0} = 4'($urandom);
        repeat (4) tick(0, 24'($urandom));
        for (int i = 0; i < n; i++) begin
            pat = 24'($urandom);
            sent_q.push_back(pat);
            tick(1, pat);
        end
        repeat (4) tick(0, 24'($urandom));
    endtask
endmodule

// ### testbench/test_dvf_fmt.sv
`timescale 1ns/100ps
`include "dvf_cfg.svh"
// ============================================================
// Formatter testbench
module test_dvf_fmt;
    import dvf_pkg::*;
    localparam int IDLE = 400;
    logic core_clk, rstn, link_clk, de_in, control_bit_one, control_bit_two;
    logic [7:0] ch0, ch1, ch2;
    logic [1:0] ctl0, bresp, rresp;
    logic hsync, vsync, de_out, cb1, cb2, oclk, lact, oe_n, irq;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    dvf_pixel_t even_bus, odd_bus, eb_q, ob_q;
    dvf_pixel_t ge[$], go[$];
    logic two, ev_rise, od_rise, oc_q, de_q;
    int err_total, check_count;
    logic [3:0] cfgs[7] = '{4'he, 4'ha, 4'hf, 4'hb, 4'hd, 4'h9, 4'h7};

    // ============================================================
    // Design and link source
    dvf_fmt #(.IDLE_CYC(IDLE)) dvf_fmt_i (
        .CORE_CLK(core_clk), .RSTN(rstn), .LINK_CLK(link_clk),
        .DATA_ENABLE_IN(de_in), .CH0_DATA(ch0), .CH1_DATA(ch1),
        .CH2_DATA(ch2), .CH0_CTL(ctl0), .CH1_CTL(control_bit_one), .CH2_CTL(control_bit_two),
        .EVEN_PIXEL_BUS(even_bus), .ODD_PIXEL_BUS(odd_bus),
        .HSYNC(hsync), .VSYNC(vsync), .DATA_ENABLE(de_out),
        .CONTROL_BIT_ONE(cb1), .CONTROL_BIT_TWO(cb2),
        .PIXEL_OUT_CLOCK(oclk), .LINK_ACTIVE_FLAG(lact), .PIX_OE_N(oe_n),
        .IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready)
    );
    dvf_link_src dvf_link_src_i (
        .link_clk(link_clk), .de(de_in), .ch0(ch0), .ch1(ch1), .ch2(ch2),
        .ctl0(ctl0), .control_bit_one(control_bit_one), .control_bit_two(control_bit_two)
    );

    // 100 MHz core clock
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end

    // Panel side: latch pre-edge bus values on the chosen out-clock edge
    always @(posedge core_clk) begin
        if (oclk !== oc_q && de_q === 1'b1) begin
            if (oclk === ev_rise) ge.push_back(eb_q);
            if (two && oclk === od_rise) go.push_back(ob_q);
        end
        {oc_q, de_q, eb_q, ob_q} = {oclk, de_out, even_bus, odd_bus};
    end

    // ============================================================
    // Checking and closing
    task automatic chk(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Bounded wait step; running out ends the run
    task automatic guard(inout int n);
        n++;
        if (n > 100) begin
            err_total++;
            $display("[ERR] handshake exp 1 got 0");
            results();
        end
    endtask

    // Expected pixel word: red from channel 2, green 1, blue 0
    function automatic logic [31:0] px(int i);
        logic [23:0] s;
        s = dvf_link_src_i.sent_q[i];
        return {8'h0, s[23:16], s[15:8], s[7:0]};
    endfunction

    // ============================================================
    // AXI4-Lite master
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            guard(n);
        end while (!bvalid);
        bready <= 0;
        chk("bresp", bresp, er);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 0;
            guard(n);
        end while (!rvalid);
        rready <= 0;
        chk("rresp", rresp, er);
        chk("rdata", rdata, exp);
    endtask

    // One line in a mode, then compare what the panel latched
    task automatic run(input logic [3:0] cfg);
        int n;
        dvf_pixel_t got;
        n = 2 + 2 * ($urandom % 4);
        wr(`DVF_OFS_CTRL, {28'h0, cfg}, `DVF_RESP_OKAY);
        {two, ev_rise, od_rise} = {cfg[0], cfg[2], cfg[2] ^ !cfg[1]};
        ge = {};
        go = {};
        dvf_link_src_i.line(n);
        repeat (10) @(posedge core_clk);
        chk("count", ge.size() + go.size(), n);
        for (int i = 0; i < n; i++) begin
            got = two ? (i % 2 ? go[i / 2] : ge[i / 2]) : ge[i];
            chk("pixel", got, px(i));
        end
        chk("ctl", {cb2, cb1, vsync, hsync}, {control_bit_two, control_bit_one, ctl0});
        chk("oe_n", oe_n, !cfg[3]);
        if (!cfg[0]) chk("odd", odd_bus, 0);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, rstn} = '0;
        {awaddr, araddr, wdata, wstrb} = {8'h0, 32'h0, 4'hf};
        {err_total, check_count, oc_q, de_q} = '0;
        void'($urandom(32'h7bbe));
        repeat (3) @(posedge core_clk);
        rstn <= 1;
        rd(`DVF_OFS_CTRL, 32'he, `DVF_RESP_OKAY);
        rd(`DVF_OFS_IRQ_MASK, 0, `DVF_RESP_OKAY);
        rd(`DVF_OFS_IRQ_STAT, 0, `DVF_RESP_OKAY);
        wr(`DVF_OFS_IRQ_MASK, 1, `DVF_RESP_OKAY);
        foreach (cfgs[i]) run(cfgs[i]);
        repeat (5) run(4'($urandom));
        chk("active", lact, 1);
        chk("irq", irq, 1);
        rd(`DVF_OFS_IRQ_STAT, 1, `DVF_RESP_OKAY);
        rd(`DVF_OFS_STATUS, 1, `DVF_RESP_OKAY);
        chk("irq", irq, 0);
        repeat (IDLE + 20) @(posedge core_clk);
        chk("active", lact, 0);
        chk("irq", irq, 0);
        wr(`DVF_OFS_IRQ_MASK, 3, `DVF_RESP_OKAY);
        repeat (3) @(posedge core_clk);
        chk("irq", irq, 1);
        rd(`DVF_OFS_IRQ_STAT, 2, `DVF_RESP_OKAY);
        wr(`DVF_OFS_STATUS, 0, `DVF_RESP_OKAY);
        wr(4'h2, 1, `DVF_RESP_SLVERR);
        rd(4'h6, 0, `DVF_RESP_SLVERR);
        rstn <= 0;
        repeat (3) @(posedge core_clk);
        rstn <= 1;
        rd(`DVF_OFS_CTRL, 32'he, `DVF_RESP_OKAY);
        results();
    end
endmodule
